// [hdl/rtcb_alarm_match.v]
// Combined alarm comparator over five enabled fields
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_defs.vh"
module rtcb_alarm_match (
	input  wire [39:0] cur_fields, // Counters: mday,wday,hour,min,sec from high to low
	input  wire [39:0] alm_fields, // Alarm values in the same order
	input  wire [4:0]  enables,    // Per-field alarm enables
	output wire        match       // All enabled fields equal, at least one enabled
);
	wire [4:0] ok;
	genvar i;
	generate
		for (i = 0; i < `RTCB_AEN_FIELDS; i = i + 1) begin : g_field
			assign ok[i] = ~enables[i] | (cur_fields[8*i+7:8*i] == alm_fields[8*i+7:8*i]);
		end
	endgenerate

	// With no field enabled the alarm never fires
	assign match = (|enables) & (&ok);
endmodule
`default_nettype wire

// [hdl/rtcb_core.v]
// Real-time-clock bank: timekeeping chain, interval timer, alarm and indirect access
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_defs.vh"
module rtcb_core (
	input  wire       clock,         // 200 MHz system clock
	input  wire       rst_n,         // Async reset, active low
	input  wire       tb_clk_in,     // Calibrated 32.768 kHz timebase pin
	input  wire [7:0] sfr_addr,      // Special-register address from the core
	input  wire [7:0] sfr_wdata,     // Write data
	input  wire       sfr_we,        // Write strobe, one cycle
	output reg  [7:0] sfr_rdata_q,   // Read data for sfr_addr, one cycle late
	output reg        irq_q,         // Pending interrupt level
	output reg  [7:0] cal_cfg_q      // Calibration output configuration
);
	reg [7:0] pre_q;
	reg [7:0] subsec_q;
	reg [7:0] sec_q;
	reg [7:0] min_q;
	reg [7:0] hour_q;
	reg [7:0] wday_q;
	reg [7:0] mday_q;
	reg [7:0] month_q;
	reg [7:0] year_q;
	reg [7:0] ival_cmp_q;
	reg [7:0] ival_cnt_q;
	reg [7:0] alarm_seconds_q;
	reg [7:0] alarm_minutes_q;
	reg [7:0] alarm_hours_q;
	reg [7:0] al_wday_q;
	reg [7:0] al_mday_q;
	reg [7:0] ptr_q;
	reg [7:0] dat_q;
	reg [4:0] aen_q;
	reg       irq_en_q;
	reg       it_en_q;
	reg [1:0] its_q;
	reg       it_flag_q;
	reg       al_flag_q;
	reg       key_armed_q;
	reg       rd_pend_q;
	reg       match_q;

	wire tb_rise;
	wire al_match;

	rtcb_sync_edge u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.din   (tb_clk_in),
		.rise  (tb_rise)
	);

	rtcb_alarm_match u_alarm (
		.cur_fields ({mday_q, wday_q, hour_q, min_q, sec_q}),
		.alm_fields ({al_mday_q, al_wday_q, alarm_hours_q, alarm_minutes_q, alarm_seconds_q}),
		.enables    (aen_q),
		.match      (al_match)
	);

	// Month length; year counts from a century start so every fourth year is leap
	function [7:0] month_len;
		input [7:0] mon;
		input [7:0] yr;
		begin
			case (mon)
				8'h04, 8'h06, 8'h09, 8'h0B: month_len = 8'h1E;
				8'h02:                      month_len = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
				default:                    month_len = 8'h1F;
			endcase
		end
	endfunction

	// Sub-register write decode, shared by every writable indirect location
	function hit;
		input [4:0] ptr_ix;
		input [4:0] ix;
		input       commit;
		begin
			hit = commit & (ptr_ix == ix);
		end
	endfunction

	wire sub_tick = tb_rise & (pre_q == `RTCB_PRESCALE_LAST);
	wire sec_tick = sub_tick & (subsec_q >= `RTCB_SUBSEC_MAX);
	wire min_tick = sec_tick & (sec_q >= `RTCB_SEC_MAX);
	wire hr_tick  = min_tick & (min_q >= `RTCB_MIN_MAX);
	wire day_tick = hr_tick & (hour_q >= `RTCB_HOUR_MAX);
	wire mon_tick = day_tick & (mday_q >= month_len(month_q, year_q));
	wire yr_tick  = mon_tick & (month_q >= `RTCB_MONTH_MAX);

	wire we_ctrl = sfr_we & (sfr_addr == `RTCB_SFR_CTRL);
	wire we_aen  = sfr_we & (sfr_addr == `RTCB_SFR_AEN);
	wire we_ptr  = sfr_we & (sfr_addr == `RTCB_SFR_PTR);
	wire we_dat  = sfr_we & (sfr_addr == `RTCB_SFR_DAT);
	wire commit  = we_dat & ptr_q[`RTCB_PTR_DIR_BIT] & key_armed_q;
	wire [4:0] ix = ptr_q[4:0];

	reg its_tick;
	always @* begin
		case (its_q)
			2'h0:    its_tick = sub_tick;
			2'h1:    its_tick = sec_tick;
			2'h2:    its_tick = min_tick;
			default: its_tick = hr_tick;
		endcase
	end

	// Indirect read selection; reserved and unmapped indices read zero
	reg [7:0] ind_rd;
	always @* begin
		case (ix)
			`RTCB_IX_SUBSEC:  ind_rd = subsec_q;
			`RTCB_IX_SEC:     ind_rd = sec_q;
			`RTCB_IX_MIN:     ind_rd = min_q;
			`RTCB_IX_HOUR:    ind_rd = hour_q;
			`RTCB_IX_WDAY:    ind_rd = wday_q;
			`RTCB_IX_MDAY:    ind_rd = mday_q;
			`RTCB_IX_MONTH:   ind_rd = month_q;
			`RTCB_IX_YEAR:    ind_rd = year_q;
			`RTCB_IX_IVAL:    ind_rd = ival_cmp_q;
			`RTCB_IX_ALARM_SECONDS:  ind_rd = alarm_seconds_q;
			`RTCB_IX_ALARM_MINUTES:  ind_rd = alarm_minutes_q;
			`RTCB_IX_ALARM_HOURS: ind_rd = alarm_hours_q;
			`RTCB_IX_AL_WDAY: ind_rd = al_wday_q;
			`RTCB_IX_AL_MDAY: ind_rd = al_mday_q;
			`RTCB_IX_CAL:     ind_rd = cal_cfg_q;
			default:          ind_rd = `RTCB_RST_ZERO;
		endcase
	end

	wire [7:0] ctrl_rd = {irq_en_q, al_flag_q, its_q, 1'b0, it_flag_q, it_en_q, 1'b0};

	// Timekeeping chain; a committed write wins over the carry in the same cycle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_q    <= `RTCB_RST_ZERO;
			subsec_q <= `RTCB_RST_ZERO;
			sec_q    <= `RTCB_RST_ZERO;
			min_q    <= `RTCB_RST_ZERO;
			hour_q   <= `RTCB_RST_ZERO;
			wday_q   <= `RTCB_RST_ZERO;
			mday_q   <= `RTCB_RST_MDAY;
			month_q  <= `RTCB_RST_MONTH;
			year_q   <= `RTCB_RST_ZERO;
		end else begin
			if (tb_rise)
				pre_q <= pre_q + 8'h01;
			if (hit(ix, `RTCB_IX_SUBSEC, commit))
				subsec_q <= sfr_wdata;
			else if (sub_tick)
				subsec_q <= sec_tick ? `RTCB_RST_ZERO : subsec_q + 8'h01;
			if (hit(ix, `RTCB_IX_SEC, commit))
				sec_q <= sfr_wdata;
			else if (sec_tick)
				sec_q <= min_tick ? `RTCB_RST_ZERO : sec_q + 8'h01;
			if (hit(ix, `RTCB_IX_MIN, commit))
				min_q <= sfr_wdata;
			else if (min_tick)
				min_q <= hr_tick ? `RTCB_RST_ZERO : min_q + 8'h01;
			if (hit(ix, `RTCB_IX_HOUR, commit))
				hour_q <= sfr_wdata;
			else if (hr_tick)
				hour_q <= day_tick ? `RTCB_RST_ZERO : hour_q + 8'h01;
			if (hit(ix, `RTCB_IX_WDAY, commit))
				wday_q <= sfr_wdata;
			else if (day_tick)
				wday_q <= (wday_q >= `RTCB_WDAY_MAX) ? `RTCB_RST_ZERO : wday_q + 8'h01;
			if (hit(ix, `RTCB_IX_MDAY, commit))
				mday_q <= sfr_wdata;
			else if (day_tick)
				mday_q <= mon_tick ? `RTCB_RST_MDAY : mday_q + 8'h01;
			if (hit(ix, `RTCB_IX_MONTH, commit))
				month_q <= sfr_wdata;
			else if (mon_tick)
				month_q <= yr_tick ? `RTCB_RST_MONTH : month_q + 8'h01;
			if (hit(ix, `RTCB_IX_YEAR, commit))
				year_q <= sfr_wdata;
			else if (yr_tick)
				year_q <= year_q + 8'h01;
		end
	end

	// Compare and configuration locations
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ival_cmp_q <= `RTCB_RST_ZERO;
			alarm_seconds_q   <= `RTCB_RST_ZERO;
			alarm_minutes_q   <= `RTCB_RST_ZERO;
			alarm_hours_q  <= `RTCB_RST_ZERO;
			al_wday_q  <= `RTCB_RST_ZERO;
			al_mday_q  <= `RTCB_RST_ZERO;
			cal_cfg_q  <= `RTCB_RST_ZERO;
		end else begin
			if (hit(ix, `RTCB_IX_IVAL, commit))
				ival_cmp_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_ALARM_SECONDS, commit))
				alarm_seconds_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_ALARM_MINUTES, commit))
				alarm_minutes_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_ALARM_HOURS, commit))
				alarm_hours_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_AL_WDAY, commit))
				al_wday_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_AL_MDAY, commit))
				al_mday_q <= sfr_wdata;
			if (hit(ix, `RTCB_IX_CAL, commit))
				cal_cfg_q <= sfr_wdata;
		end
	end

	// Pointer, data, key and control registers
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q       <= `RTCB_RST_ZERO;
			dat_q       <= `RTCB_RST_ZERO;
			aen_q       <= 5'h00;
			irq_en_q    <= 1'b0;
			it_en_q     <= 1'b0;
			its_q       <= 2'h0;
			key_armed_q <= 1'b0;
			rd_pend_q   <= 1'b0;
		end else begin
			// Any other write in between disarms the key
			if (sfr_we)
				key_armed_q <= (sfr_addr == `RTCB_SFR_KEY) && (sfr_wdata == `RTCB_KEY_VALUE);
			if (we_ptr)
				ptr_q <= {sfr_wdata[7], 2'h0, sfr_wdata[4:0]};
			rd_pend_q <= we_ptr & ~sfr_wdata[`RTCB_PTR_DIR_BIT];
			if (we_dat)
				dat_q <= sfr_wdata;
			else if (rd_pend_q)
				dat_q <= ind_rd;
			if (we_aen)
				aen_q <= sfr_wdata[4:0];
			if (we_ctrl) begin
				irq_en_q <= sfr_wdata[`RTCB_CTRL_IRQEN];
				its_q    <= sfr_wdata[`RTCB_CTRL_ITS_HI:`RTCB_CTRL_ITS_LO];
				it_en_q  <= sfr_wdata[`RTCB_CTRL_ITEN];
			end
		end
	end

	// Interval timer and event flags; a set in the cycle of a clear wins
	wire ival_hit = it_en_q & its_tick & ((ival_cnt_q + 8'h01) == ival_cmp_q);
	wire al_rise  = al_match & ~match_q;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ival_cnt_q <= `RTCB_RST_ZERO;
			it_flag_q  <= 1'b0;
			al_flag_q  <= 1'b0;
			match_q    <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			match_q <= al_match;
			// Disabling the timer holds its count at zero
			if (!it_en_q)
				ival_cnt_q <= `RTCB_RST_ZERO;
			else if (its_tick)
				ival_cnt_q <= ival_hit ? `RTCB_RST_ZERO : ival_cnt_q + 8'h01;
			if (ival_hit)
				it_flag_q <= 1'b1;
			else if (we_ctrl && !sfr_wdata[`RTCB_CTRL_INTERVAL_FLAG])
				it_flag_q <= 1'b0;
			// Edge of the match, so a held match does not refire after a clear
			if (al_rise)
				al_flag_q <= 1'b1;
			else if (we_ctrl && !sfr_wdata[`RTCB_CTRL_ALARM_FLAG])
				al_flag_q <= 1'b0;
			irq_q <= irq_en_q & (it_flag_q | al_flag_q);
		end
	end

	// Special-register read port
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_q <= `RTCB_RST_ZERO;
		end else begin
			case (sfr_addr)
				`RTCB_SFR_CTRL: sfr_rdata_q <= ctrl_rd;
				`RTCB_SFR_AEN:  sfr_rdata_q <= {3'h0, aen_q};
				`RTCB_SFR_PTR:  sfr_rdata_q <= ptr_q;
				`RTCB_SFR_DAT:  sfr_rdata_q <= dat_q;
				default:        sfr_rdata_q <= `RTCB_RST_ZERO;
			endcase
		end
	end
endmodule
`default_nettype wire

// [hdl/rtcb_sync_edge.v]
// Two-flop synchroniser with rising-edge pulse for the timebase pin
`timescale 1ns/1ps
`default_nettype none
module rtcb_sync_edge (
	input  wire clock, // System clock
	input  wire rst_n, // Async reset, active low
	input  wire din,   // Asynchronous pin level
	output wire rise   // One-cycle pulse per rising edge
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edge detector reads only the second stage and its delayed copy
	assign rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// [include/rtcb_defs.vh]
// Constants for the indirectly addressed real-time-clock bank
`ifndef RTCB_DEFS_VH
`define RTCB_DEFS_VH
`define RTCB_SFR_CTRL      8'hA1
`define RTCB_SFR_AEN       8'hA2
`define RTCB_SFR_PTR       8'hA3
`define RTCB_SFR_DAT       8'hA4
`define RTCB_SFR_KEY       8'hC1
`define RTCB_KEY_VALUE     8'hEA
`define RTCB_IX_SUBSEC     5'h01
`define RTCB_IX_SEC        5'h02
`define RTCB_IX_MIN        5'h03
`define RTCB_IX_HOUR       5'h04
`define RTCB_IX_WDAY       5'h05
`define RTCB_IX_MDAY       5'h06
`define RTCB_IX_MONTH      5'h07
`define RTCB_IX_YEAR       5'h08
`define RTCB_IX_IVAL       5'h09
`define RTCB_IX_ALARM_SECONDS     5'h0A
`define RTCB_IX_ALARM_MINUTES     5'h0B
`define RTCB_IX_ALARM_HOURS    5'h0C
`define RTCB_IX_AL_WDAY    5'h0D
`define RTCB_IX_AL_MDAY    5'h0E
`define RTCB_IX_CAL        5'h0F
`define RTCB_PTR_DIR_BIT   7
`define RTCB_CTRL_IRQEN    7
`define RTCB_CTRL_ALARM_FLAG   6
`define RTCB_CTRL_ITS_HI   5
`define RTCB_CTRL_ITS_LO   4
`define RTCB_CTRL_INTERVAL_FLAG   2
`define RTCB_CTRL_ITEN     1
`define RTCB_AEN_FIELDS    5
`define RTCB_RST_ZERO      8'h00
`define RTCB_RST_MDAY      8'h01
`define RTCB_RST_MONTH     8'h01
`define RTCB_TB_HZ         32768
`define RTCB_SUBSEC_HZ     128
`define RTCB_PRESCALE      (`RTCB_TB_HZ / `RTCB_SUBSEC_HZ)
`define RTCB_PRESCALE_LAST 8'hFF
`define RTCB_SUBSEC_MAX    8'h7F
`define RTCB_SEC_MAX       8'h3B
`define RTCB_MIN_MAX       8'h3B
`define RTCB_HOUR_MAX      8'h17
`define RTCB_WDAY_MAX      8'h06
`define RTCB_MONTH_MAX     8'h0C
`define RTCB_FEB           8'h02
`endif

// [verification/rtcb_core_asserts.sv]
// Port-level assertions for the real-time-clock bank
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_defs.vh"
module rtcb_core_asserts (
	input wire logic       clock,       // System clock
	input wire logic       rst_n,       // Async reset, active low
	input wire logic       tb_clk_in,   // Timebase pin
	input wire logic [7:0] sfr_addr,    // Register address
	input wire logic [7:0] sfr_wdata,   // Write data
	input wire logic       sfr_we,      // Write strobe
	input wire logic [7:0] sfr_rdata_q, // Read data
	input wire logic       irq_q,       // Interrupt level
	input wire logic [7:0] cal_cfg_q    // Calibration config
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire key_wr = sfr_we && sfr_addr == `RTCB_SFR_KEY && sfr_wdata == `RTCB_KEY_VALUE;
	wire dat_wr = sfr_we && sfr_addr == `RTCB_SFR_DAT;
	wire ctl_wr = sfr_we && sfr_addr == `RTCB_SFR_CTRL;

	AST_RST_OUT: assert property ($rose(rst_n) |-> !irq_q && cal_cfg_q == 8'h00)
		else $error("outputs not clear after reset");
	AST_CAL_KEY: assert property (!$stable(cal_cfg_q) |-> $past(dat_wr) && $past(key_wr, 2))
		else $error("calibration config changed without key sequence");
	AST_CAL_HOLD: assert property (!sfr_we |=> $stable(cal_cfg_q))
		else $error("calibration config changed without a write");
	AST_UNMAPPED: assert property (sfr_addr < `RTCB_SFR_CTRL || sfr_addr == `RTCB_SFR_KEY
		|=> sfr_rdata_q == 8'h00) else $error("unmapped or key address read nonzero");
	AST_CTRL_RSVD: assert property (sfr_addr == `RTCB_SFR_CTRL
		|=> sfr_rdata_q[3] == 1'b0 && sfr_rdata_q[0] == 1'b0) else $error("control spare bits set");
	AST_PTR_RSVD: assert property (sfr_addr == `RTCB_SFR_PTR |=> sfr_rdata_q[6:5] == 2'b00)
		else $error("pointer reserved bits set");
	AST_IRQ_FALL: assert property ($fell(irq_q) |-> $past(ctl_wr) || $past(ctl_wr, 2))
		else $error("interrupt dropped without control write");
	AST_IRQ_OFF: assert property (ctl_wr && !sfr_wdata[7] |-> ##2 !irq_q)
		else $error("interrupt high while disabled");
	AST_CAL_DATA: assert property (!$stable(cal_cfg_q) |-> cal_cfg_q == $past(sfr_wdata))
		else $error("calibration config took other than the written value");

	cover property ($rose(irq_q));
	cover property ($rose(tb_clk_in));
	cover property (!$stable(cal_cfg_q));
	cover property (key_wr ##1 dat_wr);
endmodule
`default_nettype wire

// [verification/rtcb_core_tb.sv]
// Self-checking testbench for the real-time-clock bank
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_defs.vh"
module rtcb_core_tb;
	localparam int TB_CLKS = 4;
	logic       clock;
	logic       rst_n;
	logic       tb_clk_in;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_we;
	logic [7:0] sfr_rdata_q;
	logic       irq_q;
	logic [7:0] cal_cfg_q;
	logic [7:0] v;
	int         fail_count;
	int         tests_run;

	rtcb_core DUT (.clock(clock), .rst_n(rst_n), .tb_clk_in(tb_clk_in), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata_q(sfr_rdata_q), .irq_q(irq_q),
		.cal_cfg_q(cal_cfg_q));
	rtcb_host_model host (.clock(clock), .sfr_rdata_q(sfr_rdata_q), .tb_clk_in(tb_clk_in),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (irq_q !== lvl && n < 5000);
		check({15'h0000, irq_q}, {15'h0000, lvl});
	endtask
	task automatic t_reset();
		for (int i = 2; i < 16; i++) begin
			host.reg_rd(i[4:0], v);
			check(v, (i == 6 || i == 7) ? 8'h01 : 8'h00);
		end
		check(cal_cfg_q, 8'h00);
	endtask
	task automatic t_calreg();
		host.reg_wr(`RTCB_IX_CAL, 8'h5A);
		check(cal_cfg_q, 8'h5A);
		host.reg_rd(`RTCB_IX_CAL, v);
		check(v, 8'h5A);
		host.wr(`RTCB_SFR_PTR, 8'h8F);
		host.wr(`RTCB_SFR_DAT, 8'h33);
		host.wr(`RTCB_SFR_DAT, 8'h33);
		host.wr(`RTCB_SFR_KEY, `RTCB_KEY_VALUE);
		host.wr(`RTCB_SFR_AEN, 8'h00);
		host.wr(`RTCB_SFR_DAT, 8'h33);
		host.idle();
		#20;
		check(cal_cfg_q, 8'h5A);
		host.reg_wr(5'h00, 8'h77);
		host.reg_rd(5'h00, v);
		check(v, 8'h00);
	endtask
	// Preset 23:59:59 on day md of month mo, sub-second last so the carry comes after
	task automatic t_roll(input logic [7:0] md, mo, yr, emd, emo, eyr);
		logic [7:0] pre [1:8];
		logic [7:0] post [1:8];
		int n;
		pre = '{`RTCB_SUBSEC_MAX, `RTCB_SEC_MAX, `RTCB_MIN_MAX, `RTCB_HOUR_MAX,
			`RTCB_WDAY_MAX, md, mo, yr};
		post = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, emd, emo, eyr};
		for (int i = 8; i > 0; i--) begin
			host.reg_wr(i[4:0], pre[i]);
		end
		n = 0;
		v = `RTCB_HOUR_MAX;
		while (v !== 8'h00 && n < 300) begin
			host.reg_rd(`RTCB_IX_HOUR, v);
			n++;
		end
		for (int i = 1; i < 9; i++) begin
			host.reg_rd(i[4:0], v);
			check(v, post[i]);
		end
	endtask
	task automatic t_interval();
		realtime t0;
		int cyc;
		host.reg_wr(`RTCB_IX_IVAL, 8'h03);
		host.wr(`RTCB_SFR_CTRL, 8'h82);
		host.idle();
		wait_irq(1'b1);
		t0 = $realtime;
		host.sfr_rd(`RTCB_SFR_CTRL, v);
		check(v & 8'h04, 8'h04);
		host.wr(`RTCB_SFR_CTRL, 8'h82);
		host.idle();
		wait_irq(1'b0);
		wait_irq(1'b1);
		cyc = int'(($realtime - t0) / 5.0);
		check(cyc[15:0], 16'(3 * `RTCB_PRESCALE * TB_CLKS));
		host.wr(`RTCB_SFR_CTRL, 8'h00);
		host.idle();
		// Seconds timebase: sub-second preset two ticks short, so a sub-second pick fires early
		host.reg_wr(`RTCB_IX_IVAL, 8'h01);
		host.reg_wr(`RTCB_IX_SUBSEC, 8'h7E);
		host.wr(`RTCB_SFR_CTRL, 8'h92);
		host.idle();
		wait_irq(1'b1);
		host.reg_rd(`RTCB_IX_SUBSEC, v);
		check(v, 8'h00);
		host.wr(`RTCB_SFR_CTRL, 8'h00);
		host.idle();
	endtask
	task automatic t_alarm();
		host.reg_wr(`RTCB_IX_ALARM_SECONDS, 8'h05);
		host.reg_wr(`RTCB_IX_ALARM_MINUTES, 8'h07);
		host.reg_wr(`RTCB_IX_ALARM_HOURS, 8'h09);
		host.reg_wr(`RTCB_IX_SEC, 8'h05);
		host.reg_wr(`RTCB_IX_MIN, 8'h06);
		host.wr(`RTCB_SFR_AEN, 8'h03);
		host.wr(`RTCB_SFR_CTRL, 8'h80);
		host.idle();
		#50;
		check({15'h0000, irq_q}, 16'h0000);
		host.reg_wr(`RTCB_IX_MIN, 8'h07);
		check({15'h0000, irq_q}, 16'h0001);
		host.sfr_rd(`RTCB_SFR_CTRL, v);
		check(v, 8'hC0);
		host.wr(`RTCB_SFR_CTRL, 8'h80);
		host.idle();
		#20;
		check({15'h0000, irq_q}, 16'h0000);
		// Break the match first, then enable all five with only the day of month off
		host.reg_wr(`RTCB_IX_SEC, 8'h04);
		host.reg_wr(`RTCB_IX_AL_WDAY, 8'h03);
		host.reg_wr(`RTCB_IX_AL_MDAY, 8'h14);
		host.reg_wr(`RTCB_IX_WDAY, 8'h03);
		host.reg_wr(`RTCB_IX_MDAY, 8'h13);
		host.reg_wr(`RTCB_IX_HOUR, 8'h09);
		host.wr(`RTCB_SFR_AEN, 8'h1F);
		host.reg_wr(`RTCB_IX_SEC, 8'h05);
		check({15'h0000, irq_q}, 16'h0000);
		host.reg_wr(`RTCB_IX_MDAY, 8'h14);
		check({15'h0000, irq_q}, 16'h0001);
		host.wr(`RTCB_SFR_CTRL, 8'h00);
		host.idle();
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		rst_n = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_calreg();
		t_roll(8'h1F, 8'h0C, 8'hFF, 8'h01, 8'h01, 8'h00);
		t_roll(8'h1E, 8'h04, 8'h00, 8'h01, 8'h05, 8'h00);
		t_roll(8'h1C, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01);
		t_roll(8'h1C, 8'h02, 8'h04, 8'h1D, 8'h02, 8'h04);
		t_interval();
		t_alarm();
		results();
	end
	// About three times the expected run length
	initial begin
		#200000;
		fail_count++;
		results();
	end
endmodule

bind rtcb_core rtcb_core_asserts u_chk (.clock(clock), .rst_n(rst_n), .tb_clk_in(tb_clk_in),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata_q(sfr_rdata_q),
	.irq_q(irq_q), .cal_cfg_q(cal_cfg_q));
`default_nettype wire

// [verification/rtcb_host_model.sv]
// Host core model: register cycles and a sped-up timebase
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_defs.vh"
module rtcb_host_model (
	input  wire logic       clock,       // System clock
	input  wire logic [7:0] sfr_rdata_q, // Read data from the bank
	output var  logic       tb_clk_in,   // Timebase, one rising edge per four clocks
	output var  logic [7:0] sfr_addr,    // Register address
	output var  logic [7:0] sfr_wdata,   // Write data
	output var  logic       sfr_we       // Write strobe
);
	logic ph_q;
	initial begin
		ph_q = 1'b0;
		tb_clk_in = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_we = 1'b0;
	end
	// Two-clock levels stay wide enough for the two-flop synchroniser
	always @(posedge clock) begin
		ph_q <= ~ph_q;
		if (ph_q) begin
			tb_clk_in <= ~tb_clk_in;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_we <= 1'b1;
	endtask
	task automatic idle();
		@(posedge clock);
		sfr_we <= 1'b0;
	endtask
	task automatic reg_wr(input logic [4:0] ix, input logic [7:0] d);
		wr(`RTCB_SFR_PTR, {3'b100, ix});
		wr(`RTCB_SFR_KEY, `RTCB_KEY_VALUE);
		wr(`RTCB_SFR_DAT, d);
		idle();
		#20;
	endtask
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		repeat (2) @(posedge clock);
		#1 d = sfr_rdata_q;
	endtask
	task automatic reg_rd(input logic [4:0] ix, output logic [7:0] d);
		wr(`RTCB_SFR_PTR, {3'b000, ix});
		idle();
		sfr_rd(`RTCB_SFR_DAT, d);
	endtask
endmodule
`default_nettype wire
